// *** hw/eight_bit_counter_unit.sv ***
// Function
// [R1] Clock source select clear: count once per instruction cycle without prescaler.
// [R2] A write to the count register holds off counting for two cycles.
// [R3] Clock source select set: count edges of the external count pin.
// [R4] Source edge select clear picks rising edges, set picks falling edges.
// [R5] Prescaler assignment routes the one prescaler to timer or watchdog only.
// [R6] Timer prescaler divides by a power of two from 2 to 256.
// [R7] Prescaler count is never readable and never loadable by software.
// [R8] Pin or prescaler output is sampled on phases Q2 and Q4.
// [R9] Without prescaler the pin stays high two and low two periods.
// [R10] With prescaler the pin period is at least four periods over ratio.
// [R11] Prescaler divides the pin level ahead of phase sampling, output symmetrical.
// [R12] Count steps three to seven periods after a pin change.
// [R13] The shared prescaler is an eight-bit counter.
// [R14] Count writes clear the prescaler while it belongs to the timer.
// [R15] Watchdog clear clears the prescaler while it belongs to the watchdog.
// [R16] Reset leaves the prescaler at all zeros.
// [R17] Count register is eight bits, read and write, at data address one.
// [R18] Software clears watchdog, count and prescaler before moving it to watchdog.
// [R19] Software clears watchdog then writes assignment clear to move it back.
// [R20] Assigned to the watchdog the prescaler divides its time-out up to 128.
// [R21] Timer ratio is two to the power of ratio select plus one.
// [R22] The count wraps from its maximum to zero and keeps counting.
`timescale 1ns/100ps
`default_nettype none

module eight_bit_counter_unit
  import timer_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 8
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       cfg_wr_i,
  input  wire logic       watchdog_clear_i,
  input  wire logic       external_count_pin_i,
  input  wire logic       watchdog_tick_i,
  output var  logic [7:0] rdata_o,
  output var  logic [7:0] count_o,
  output var  logic       watchdog_timeout_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  prescaler_if #(.WIDTH(PRESCALE_WIDTH)) pre ();

  logic [7:0] cfg;
  logic [7:0] count;
  logic [1:0] holdoff;
  phase_e     phase;
  phase_e     next_phase;
  logic       pin_meta;
  logic       pin_sync;
  logic       edge_level_d;
  logic       wdt_meta;
  logic       wdt_sync;
  logic       wdt_sync_d;
  logic       sampled;
  logic       sampled_d;
  logic       pre_level_d;
  logic       wdog_level_d;

  logic       clock_source_select;
  logic       source_edge_select;
  logic       prescaler_assignment;
  logic [2:0] ratio_select;
  logic       count_write;
  logic       edge_level;
  logic       ext_edge;
  logic       wdt_edge;
  logic       pre_level;
  logic       wdog_level;
  logic       src_level;
  logic       sample_now;
  logic       inc_req;
  logic       inc_ok;
  logic       next_timeout;

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // Write-only from the CPU; upper two bits are unimplemented and stay low
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg <= CFG_RESET;
    end else if (cfg_wr_i) begin
      cfg <= {2'h0, wdata_i[CFG_USED_MSB:0]};
    end
  end

  // Field decode
  assign clock_source_select  = cfg[CLOCK_SOURCE_SELECT_BIT];
  assign source_edge_select   = cfg[SOURCE_EDGE_SELECT_BIT];
  assign prescaler_assignment = cfg[PRESCALER_ASSIGN_BIT];
  assign ratio_select         = cfg[RATIO_SELECT_MSB:RATIO_SELECT_LSB];
  assign count_write          = wr_i && (addr_i == COUNT_ADDR);    // [R17]

  // ----------------------------------------------------------------
  // Phase clocks
  // ----------------------------------------------------------------
  // Four oscillator periods per instruction cycle, Q1 to Q4
  always_comb begin
    case (phase)
      PH_Q1:   next_phase = PH_Q2;
      PH_Q2:   next_phase = PH_Q3;
      PH_Q3:   next_phase = PH_Q4;
      PH_Q4:   next_phase = PH_Q1;
      default: next_phase = PH_Q1;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase <= PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Pin and watchdog base tick come from outside this clock domain
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta   <= 1'b0;
      pin_sync   <= 1'b0;
      wdt_meta   <= 1'b0;
      wdt_sync   <= 1'b0;
      wdt_sync_d <= 1'b0;
    end else begin
      pin_meta   <= external_count_pin_i;
      pin_sync   <= pin_meta;
      wdt_meta   <= watchdog_tick_i;
      wdt_sync   <= wdt_meta;
      wdt_sync_d <= wdt_sync;
    end
  end

  // Inverting the pin turns falling edges into rising ones
  assign edge_level = pin_sync ^ source_edge_select;            // [R4]
  assign ext_edge   = rising(edge_level_d, edge_level);
  assign wdt_edge   = rising(wdt_sync_d, wdt_sync);

  // ----------------------------------------------------------------
  // Shared prescaler routing
  // ----------------------------------------------------------------
  // Only one consumer feeds the divider at a time
  always_comb begin
    if (prescaler_assignment) begin
      pre.tick = wdt_edge;                                      // [R5] [R20]
    end else if (clock_source_select) begin
      pre.tick = ext_edge;                                      // [R11]
    end else begin
      pre.tick = (phase == PH_Q4);                              // [R6]
    end
  end

  // Clear follows the owner: count writes for the timer, watchdog clear otherwise
  assign pre.clear = (count_write && !prescaler_assignment)    // [R14]
                   || (watchdog_clear_i && prescaler_assignment); // [R15]

  prescaler_counter #(
    .WIDTH (PRESCALE_WIDTH)
  ) u_prescaler (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .ps     (pre)
  );

  // Bit n toggles every 2^n ticks, so a rise of bit n divides by 2^(n+1)
  assign pre_level  = pick(pre.value[7:0], ratio_select);       // [R21]
  // Watchdog ratio is one lower: bit n-1 gives 1:2^n, zero passes the tick
  assign wdog_level = pick(pre.value[7:0], ratio_select - 3'h1); // [R20]

  // ----------------------------------------------------------------
  // Phase sampling of the counting source
  // ----------------------------------------------------------------
  // Raw level without prescaler, divided level with it
  assign src_level  = prescaler_assignment ? edge_level : pre_level;
  assign sample_now = (phase == PH_Q2) || (phase == PH_Q4);      // [R8]

  // Edge history starts at the idle level of a low pin under the reset edge
  // select, so leaving reset never looks like a counting edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sampled      <= CFG_RESET[SOURCE_EDGE_SELECT_BIT];
      sampled_d    <= CFG_RESET[SOURCE_EDGE_SELECT_BIT];
      edge_level_d <= CFG_RESET[SOURCE_EDGE_SELECT_BIT];
      pre_level_d  <= 1'b0;
      wdog_level_d <= 1'b0;
    end else begin
      if (sample_now) begin
        sampled <= src_level;                                   // [R8] [R12]
      end
      sampled_d    <= sampled;
      edge_level_d <= edge_level;
      pre_level_d  <= pre_level;
      // A clear drops the tap to zero; forget its history so no fall is seen
      wdog_level_d <= pre.clear ? 1'b0 : wdog_level;            // [R15]
    end
  end

  // ----------------------------------------------------------------
  // Increment request
  // ----------------------------------------------------------------
  // Counter mode waits for the sampled rise; timer mode counts cycles
  always_comb begin
    if (clock_source_select) begin
      inc_req = rising(sampled_d, sampled);                     // [R3] [R12]
    end else if (prescaler_assignment) begin
      inc_req = (phase == PH_Q4);                               // [R1]
    end else begin
      inc_req = rising(pre_level_d, pre_level);                 // [R6]
    end
  end

  assign inc_ok = inc_req && (holdoff == 2'h0);                 // [R2]

  // ----------------------------------------------------------------
  // Write hold-off
  // ----------------------------------------------------------------
  // Counted in instruction cycles; software may pre-adjust the written value
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      holdoff <= 2'h0;
    end else if (count_write) begin
      holdoff <= HOLDOFF_CYCLES;                                // [R2]
    end else if ((phase == PH_Q4) && (holdoff != 2'h0)) begin
      holdoff <= holdoff - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Count register
  // ----------------------------------------------------------------
  // A write beats an increment in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= COUNT_RESET;
    end else if (count_write) begin
      count <= wdata_i;                                         // [R17]
    end else if (inc_ok) begin
      count <= count + 8'h01;                                   // [R22]
    end
  end

  assign count_o = count;

  // Only the count is visible; the prescaler has no read path
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= READ_IDLE;
    end else begin
      rdata_o <= (addr_i == COUNT_ADDR) ? count : READ_IDLE;    // [R7] [R17]
    end
  end

  // ----------------------------------------------------------------
  // Watchdog time-out strobe
  // ----------------------------------------------------------------
  // Without the prescaler or at ratio zero every base tick is a time-out; otherwise the tap's
  // fall marks a full period, so a clear restarts a whole time-out
  always_comb begin
    if (!prescaler_assignment || (ratio_select == 3'h0)) begin
      next_timeout = wdt_edge;
    end else begin
      next_timeout = rising(wdog_level, wdog_level_d);          // [R20]
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      watchdog_timeout_o <= 1'b0;
    end else begin
      watchdog_timeout_o <= next_timeout;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_timer_cycle_step: assert property ( // [R1]
    !clock_source_select && prescaler_assignment && phase == PH_Q4 && holdoff == 2'h0
    && !count_write |=> count == $past(count) + 8'h01)
    else $error("timer mode missed its cycle increment");

  a_write_loads: assert property ( // [R2]
    count_write |=> count == $past(wdata_i) && holdoff == HOLDOFF_CYCLES)
    else $error("count write not loaded or hold-off not armed");

  a_holdoff_freezes: assert property ( // [R2]
    holdoff != 2'h0 && !count_write |=> $stable(count))
    else $error("count moved during write hold-off");

  a_holdoff_length: assert property ( // [R2]
    count_write ##1 !count_write [*8] |=> holdoff == 2'h0)
    else $error("hold-off outlasted two cycles");

  a_sample_phase: assert property ( // [R8]
    $changed(sampled) |-> $past(phase) == PH_Q2 || $past(phase) == PH_Q4)
    else $error("source sampled outside Q2 or Q4");

  a_pin_to_count: assert property ( // [R12]
    clock_source_select && prescaler_assignment && $rose(edge_level)
    ##1 (holdoff == 2'h0 && !count_write && !cfg_wr_i) [*3]
    |-> $past(count, 2) != count || $past(count, 1) != count)
    else $error("pin edge did not reach the count in time");

  a_wdt_owns_tick: assert property ( // [R5]
    prescaler_assignment |-> pre.tick == wdt_edge)
    else $error("timer source reached watchdog prescaler");

  a_timer_clear: assert property ( // [R14]
    count_write && !prescaler_assignment |=> pre.value == '0)
    else $error("count write left prescaler uncleared");

  a_wdt_clear: assert property ( // [R15]
    watchdog_clear_i && prescaler_assignment |=> pre.value == '0)
    else $error("watchdog clear left prescaler uncleared");

  a_count_wraps: assert property ( // [R22]
    count == 8'hff && inc_ok && !count_write |=> count == 8'h00)
    else $error("count did not wrap to zero");

  c_timer_wrap:  cover property (!clock_source_select && count == 8'hff ##1 count == 8'h00);
  c_pin_count:   cover property (clock_source_select && inc_ok);
  c_wdt_timeout: cover property (prescaler_assignment && ratio_select == 3'h7
                                 && watchdog_timeout_o);
  c_prescaled:   cover property (!prescaler_assignment && ratio_select == 3'h7 && inc_ok);

endmodule : eight_bit_counter_unit

`default_nettype wire

// *** hw/prescaler_counter.sv ***
`timescale 1ns/100ps
`default_nettype none

module prescaler_counter
  import timer_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  prescaler_if.unit   ps
);

  // ----------------------------------------------------------------
  // Divider counter
  // ----------------------------------------------------------------
  // Clear beats a tick in the same cycle so a write never leaves a stale count
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ps.value <= WIDTH'(PRESCALE_RESET);                      // [R16]
    end else if (ps.clear) begin
      ps.value <= '0;                                          // [R14] [R15]
    end else if (ps.tick) begin
      ps.value <= ps.value + WIDTH'(1);                        // [R13]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_tick_advances: assert property (ps.tick && !ps.clear |=> ps.value == $past(ps.value) + WIDTH'(1)) // [R13]
    else $error("prescaler did not advance on tick");
  a_clear_zeroes: assert property (ps.clear |=> ps.value == '0) // [R14]
    else $error("prescaler not zero after clear");
  a_idle_holds: assert property (!ps.tick && !ps.clear |=> $stable(ps.value)) // [R7]
    else $error("prescaler moved without tick");

endmodule : prescaler_counter

`default_nettype wire

// *** hw/prescaler_if.sv ***
`timescale 1ns/100ps
`default_nettype none

// Shared prescaler link between the counter core and its divider
interface prescaler_if #(parameter int WIDTH = 8);
  logic             tick;
  logic             clear;
  logic [WIDTH-1:0] value;

  modport owner (output tick, output clear, input value);
  modport unit  (input tick, input clear, output value);
endinterface : prescaler_if

`default_nettype wire

// *** hw/timer_pkg.sv ***
package timer_pkg;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNT_ADDR     = 8'h01;
  localparam logic [7:0] COUNT_RESET    = 8'h00;
  localparam logic [7:0] CFG_RESET      = 8'h3f;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE      = 8'h00;

  // ----------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------
  localparam int CLOCK_SOURCE_SELECT_BIT = 5;
  localparam int SOURCE_EDGE_SELECT_BIT  = 4;
  localparam int PRESCALER_ASSIGN_BIT    = 3;
  localparam int RATIO_SELECT_MSB        = 2;
  localparam int RATIO_SELECT_LSB        = 0;
  localparam int CFG_USED_MSB            = 5;

  // ----------------------------------------------------------------
  // Timing: one clock is one oscillator period, four make a cycle
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         TOSC_NS         = 10;
  localparam int         TOSC_CLOCKS     = (TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         PHASES_PER_CYC  = 4 * TOSC_CLOCKS;
  localparam logic [1:0] HOLDOFF_CYCLES  = 2'h2;

  // Internal phase clocks of one instruction cycle
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;

  // One-cycle pulse on a low-to-high step between two samples
  function automatic logic rising(input logic prev, input logic cur);
    rising = cur & ~prev;
  endfunction : rising

  // Pick one bit of the prescaler by index
  function automatic logic pick(input logic [7:0] value, input logic [2:0] idx);
    pick = value[idx];
  endfunction : pick

endpackage : timer_pkg

// *** tb/count_pin_source.sv ***
`timescale 1ns/100ps
`default_nettype none

// External source on the count pin; the line rests where it was left
module count_pin_source (
  input  wire logic clk_i,
  output var  logic pin_o
);
  initial pin_o = 1'b0;

  // Level changes land just after an edge so the sampler never races them
  task automatic set_level(input logic v);
    @(posedge clk_i);
    pin_o <= v;
  endtask : set_level

  // Burst of pulses; widths never below two periods each side
  task automatic pulses(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      set_level(1'b1);
      repeat (hi - 1) @(posedge clk_i);
      set_level(1'b0);
      repeat (lo - 1) @(posedge clk_i);
    end
  endtask : pulses
endmodule : count_pin_source

`default_nettype wire

// *** tb/timer_counter_with_shared_prescaler_bench.sv ***
`timescale 1ns/100ps
`default_nettype none

module timer_counter_with_shared_prescaler_bench;
  import timer_pkg::*;
  localparam int LIMIT = 20000;
  logic       clk_i, rstn_i, wr_i, cfg_wr_i, watchdog_clear_i, watchdog_tick_i;
  logic [7:0] addr_i, wdata_i;
  wire  logic pin;
  wire  logic [7:0] rdata_o, count_o;
  wire  logic watchdog_timeout_o;
  int         bad_count, samples_checked, cycles, tmo_count;

  eight_bit_counter_unit uut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wr_i(wr_i),
    .wdata_i(wdata_i), .cfg_wr_i(cfg_wr_i), .watchdog_clear_i(watchdog_clear_i),
    .external_count_pin_i(pin), .watchdog_tick_i(watchdog_tick_i), .rdata_o(rdata_o),
    .count_o(count_o), .watchdog_timeout_o(watchdog_timeout_o));
  count_pin_source src (.clk_i(clk_i), .pin_o(pin));

  // ----------------------------------------------------------------
  // Clock, hang guard and time-out pulse monitor
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Cut a hang short; the ceiling is well above the expected run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      print_verdict();
    end
  end

  // Pulses are one cycle wide, so each high sample is one time-out
  always @(posedge clk_i) begin
    if (watchdog_timeout_o === 1'b1) tmo_count++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic check_span(input string what, input int lo, input int hi, input int seen);
    samples_checked++;
    if (seen < lo || seen > hi) begin
      bad_count++;
      $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask : check_span

  // Strobe is held one cycle only; a CPU instruction issues one access
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, input logic cfg);
    @(posedge clk_i);
    addr_i   <= a;
    wdata_i  <= d;
    wr_i     <= ~cfg;
    cfg_wr_i <= cfg;
    @(posedge clk_i);
    wr_i     <= 1'b0;
    cfg_wr_i <= 1'b0;
  endtask : bus_wr

  task automatic wd_clear();
    @(posedge clk_i);
    watchdog_clear_i <= 1'b1;
    @(posedge clk_i);
    watchdog_clear_i <= 1'b0;
  endtask : wd_clear

  task automatic wd_tick();
    @(posedge clk_i);
    watchdog_tick_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    watchdog_tick_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : wd_tick

  // Counts clocks until the count moves; bounded so a stuck count cannot hang
  task automatic wait_step(input int limit, output int n);
    logic [7:0] v;
    v = count_o;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (count_o === v && n < limit);
  endtask : wait_step

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    check_byte("count after reset", COUNT_RESET, count_o);
    check_byte("read after reset", READ_IDLE, rdata_o);
    repeat (16) @(posedge clk_i);
    #1;
    check_byte("count idle pin", 8'h00, count_o);
    $display("test reset done");
  endtask : test_reset

  task automatic test_timer_plain();
    int n;
    bus_wr(8'h00, 8'h08, 1'b1);
    bus_wr(COUNT_ADDR, 8'hff, 1'b0);
    @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    #1;
    check_byte("count in holdoff", 8'hff, count_o);
    wait_step(12, n);
    check_byte("count wrap", 8'h00, count_o);
    wait_step(12, n);
    repeat (40) @(posedge clk_i);
    #1;
    check_byte("count rate", 8'h0b, count_o);
    $display("test timer plain done");
  endtask : test_timer_plain

  task automatic test_prescale();
    int n;
    wd_clear();
    for (int r = 0; r < 8; r++) begin
      bus_wr(8'h00, 8'(r), 1'b1);
      // First step may be a ratio-switch artefact, second may be partial
      wait_step(2100, n);
      wait_step(2100, n);
      wait_step(2100, n);
      check_span("prescaled period", 4 << (r + 1), 4 << (r + 1), n);
    end
    repeat (500) @(posedge clk_i);
    bus_wr(COUNT_ADDR, 8'h55, 1'b0);
    #1;
    check_byte("count after write", 8'h55, count_o);
    // A cleared prescaler needs at least half its period before the first step
    wait_step(1100, n);
    check_span("clear to first step", 510, 1030, n);
    check_byte("count after clear", 8'h56, count_o);
    @(posedge clk_i);
    addr_i <= COUNT_ADDR;
    repeat (2) @(posedge clk_i);
    #1;
    check_byte("read count", 8'h56, rdata_o);
    bus_wr(8'h02, 8'haa, 1'b0);
    repeat (2) @(posedge clk_i);
    #1;
    check_byte("read other", READ_IDLE, rdata_o);
    check_byte("count other write", 8'h56, count_o);
    $display("test prescale done");
  endtask : test_prescale

  task automatic test_counter();
    int n;
    logic [7:0] v;
    bus_wr(8'h00, 8'h28, 1'b1);
    repeat (12) @(posedge clk_i);
    v = count_o;
    src.set_level(1'b1);
    wait_step(10, n);
    check_span("pin delay", 3, 7, n);
    src.set_level(1'b0);
    repeat (10) @(posedge clk_i);
    src.set_level(1'b1);
    repeat (10) @(posedge clk_i);
    #1;
    check_byte("rising only", v + 8'h02, count_o);
    bus_wr(8'h00, 8'h38, 1'b1);
    repeat (10) @(posedge clk_i);
    v = count_o;
    src.set_level(1'b0);
    wait_step(10, n);
    check_span("fall delay", 3, 7, n);
    src.pulses(6, 2, 2);
    repeat (10) @(posedge clk_i);
    #1;
    check_byte("short pulses", v + 8'h07, count_o);
    bus_wr(8'h00, 8'h30, 1'b1);
    bus_wr(COUNT_ADDR, 8'h00, 1'b0);
    repeat (12) @(posedge clk_i);
    src.pulses(8, 2, 2);
    repeat (10) @(posedge clk_i);
    #1;
    check_byte("pin prescaled", 8'h04, count_o);
    $display("test counter done");
  endtask : test_counter

  task automatic test_watchdog();
    int t;
    wd_clear();
    bus_wr(COUNT_ADDR, 8'h00, 1'b0);
    bus_wr(8'h00, 8'h09, 1'b1);
    wd_clear();
    t = tmo_count;
    repeat (4) wd_tick();
    check_span("timeouts ratio 2", t + 2, t + 2, tmo_count);
    wd_clear();
    t = tmo_count;
    wd_tick();
    wd_clear();
    wd_tick();
    check_span("timeouts after clear", t, t, tmo_count);
    bus_wr(8'h00, 8'h00, 1'b1);
    t = tmo_count;
    repeat (2) wd_tick();
    check_span("timeouts unscaled", t + 2, t + 2, tmo_count);
    $display("test watchdog done");
  endtask : test_watchdog

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    cfg_wr_i = 1'b0;
    watchdog_clear_i = 1'b0;
    watchdog_tick_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    #1;
    test_reset();
    test_timer_plain();
    test_prescale();
    test_counter();
    test_watchdog();
    print_verdict();
  end
endmodule : timer_counter_with_shared_prescaler_bench

`default_nettype wire
